// file: include/ptr_pkg.sv
// shared constants, types and helpers of the pmbus telemetry responder
package ptr_pkg;

  // ==========================================================================
  // clocks and timing
  localparam int SYS_CLK_MHZ     = 100;
  localparam int LINK_CLK_NS     = 12;
  localparam int STRETCH_MAX_MS  = 25;
  // longest time, so the division rounds down
  localparam int STRETCH_MAX_CYC = STRETCH_MAX_MS * 1_000_000 / LINK_CLK_NS;
  localparam int STRETCH_CNT_W   = 22;
  localparam int FILT_TICK_MS    = 10;
  localparam int FILT_TICK_CYC   = FILT_TICK_MS * 1000 * SYS_CLK_MHZ;
  localparam int FILT_CNT_W      = 20;
  // alpha 1/32 at a 10 ms update gives about 0.5 Hz bandwidth
  localparam int FILT_SHIFT      = 5;
  localparam int FRAC_W          = 8;
  // eight filter ticks (80 ms) make one energy sample period
  localparam logic [2:0] SAMPLE_LAST  = 3'h7;
  localparam int         SAMPLE_SHIFT = 3;

  // ==========================================================================
  // widths
  localparam int CMD_W   = 8;
  localparam int DATA_W  = 16;
  localparam int RSP_W   = 48;
  localparam int PACC_W  = 15;
  localparam int ROLL_W  = 8;
  localparam int NCNT_W  = 24;
  localparam int PSUM_W  = DATA_W + SAMPLE_SHIFT;
  localparam int FILT_W  = DATA_W + FRAC_W;
  localparam int TEMP_W  = 11;
  localparam int WS_IDX_W = 3;
  localparam int WS_DEPTH = 8;
  localparam logic [PACC_W-1:0] PACC_MAX = 15'h7fff;

  // ==========================================================================
  // command codes
  localparam logic [CMD_W-1:0] CMD_READ_EIN   = 8'h86;
  localparam logic [CMD_W-1:0] CMD_READ_EOUT  = 8'h87;
  localparam logic [CMD_W-1:0] CMD_READ_IOUT  = 8'h8c;
  localparam logic [CMD_W-1:0] CMD_READ_TEMP1 = 8'h8d;
  localparam logic [CMD_W-1:0] CMD_READ_TEMP2 = 8'h8e;
  localparam logic [CMD_W-1:0] CMD_READ_PIN   = 8'h97;

  // ==========================================================================
  // linear format: 5-bit exponent over 11-bit mantissa
  localparam logic [4:0]  EXP_WATT = 5'h00;
  localparam logic [4:0]  EXP_AMP  = 5'h1d;  // -3, units of 1/8 A
  localparam logic [4:0]  EXP_TEMP = 5'h00;
  localparam logic [10:0] MANT_MAX = 11'h3ff;

  // link side request channel
  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_WR   = 2'b01,
    L_RD   = 2'b10
  } ptr_lstate_t;

  // unsigned value to linear word, saturating at the largest positive mantissa
  function automatic logic [DATA_W-1:0] lin_enc(input logic [4:0]        ex,
                                                input logic [DATA_W-1:0] v);
    lin_enc = {ex, (v > DATA_W'(MANT_MAX)) ? MANT_MAX : v[10:0]};
  endfunction : lin_enc

endpackage : ptr_pkg

// file: src/ptr_pmbus_telemetry.sv
// pmbus telemetry responder: filters, energy accumulators, link handshake
module ptr_pmbus_telemetry #(
  parameter int FILT_TICK_CYC   = ptr_pkg::FILT_TICK_CYC,   // filter update period
  parameter int STRETCH_MAX_CYC = ptr_pkg::STRETCH_MAX_CYC  // stretch limit, link cycles
) (
  input  wire logic                        sys_clk,       // 100 MHz system clock
  input  wire logic                        reset_n,       // synchronous reset
  input  wire logic                        acPresent,     // own ac input good, pin
  input  wire logic                        unitOn,        // main output on, pin
  input  wire logic                        peerPowered,   // paralleled supply has ac, pin
  input  wire logic [ptr_pkg::DATA_W-1:0]  rawPinW,       // input power, watts
  input  wire logic [ptr_pkg::DATA_W-1:0]  rawIoutA8,     // 12 v current, 1/8 a
  input  wire logic [ptr_pkg::DATA_W-1:0]  rawPoutW,      // output power, watts
  input  wire logic [ptr_pkg::TEMP_W-1:0]  rawTempInlet,  // inlet, signed celsius
  input  wire logic [ptr_pkg::TEMP_W-1:0]  rawTempHot,    // hot spot, signed celsius
  input  wire logic                        linkClk,       // link side clock
  input  wire logic                        wrStrobe,      // host wrote a word
  input  wire logic [ptr_pkg::CMD_W-1:0]   wrCmd,         // command of that write
  input  wire logic [ptr_pkg::DATA_W-1:0]  wrData,        // data of that write
  input  wire logic                        rdStrobe,      // host started a read
  input  wire logic [ptr_pkg::CMD_W-1:0]   rdCmd,         // command of that read
  output logic                             sclHold,       // hold scl low
  output logic [ptr_pkg::RSP_W-1:0]        rdData,        // answer, byte 0 lowest
  output logic                             rdValid,       // answer ready pulse
  output logic                             rdTimeout      // stretch limit hit pulse
);

  // ==========================================================================
  // link domain
  logic                          linkRstS1_ff, linkRstS2_ff;
  logic                          ackS1_ff, ackS2_ff, ackS3_ff;
  logic                          reqTog_ff;
  logic                          reqIsRd_ff;
  logic [ptr_pkg::CMD_W-1:0]     reqCmd_ff;
  logic [ptr_pkg::DATA_W-1:0]    reqData_ff;
  logic                          rdPend_ff;
  logic [ptr_pkg::CMD_W-1:0]     rdPendCmd_ff;
  logic                          timedOut_ff;
  logic [ptr_pkg::STRETCH_CNT_W-1:0] holdCnt_ff;
  ptr_pkg::ptr_lstate_t          lstate_ff;
  logic                          sclHold_ff, rdValid_ff, rdTimeout_ff;
  logic [ptr_pkg::RSP_W-1:0]     rdData_ff;
  logic                          ackSeen;

  // ==========================================================================
  // system domain
  logic                          reqS1_ff, reqS2_ff, reqS3_ff;
  logic                          ackTog_ff;
  logic [ptr_pkg::RSP_W-1:0]     rsp_ff;
  logic [2:0]                    statS1_ff, statS2_ff;
  logic                          acOk, onOk, peerOk;
  logic [ptr_pkg::FILT_CNT_W-1:0] tickCnt_ff;
  logic                          tick_ff;
  logic [2:0]                    sampCnt_ff;
  logic                          sampStrobe;
  logic                          lostAll_ff;
  logic                          reqSeen;
  logic [ptr_pkg::DATA_W-1:0]    filtIn   [2];
  logic                          filtZero [2];
  logic [ptr_pkg::FILT_W-1:0]    filt_ff  [2];
  logic [ptr_pkg::DATA_W-1:0]    engIn    [2];
  logic [ptr_pkg::PSUM_W-1:0]    psum_ff  [2];
  logic [ptr_pkg::PACC_W-1:0]    pacc_ff  [2];
  logic [ptr_pkg::ROLL_W-1:0]    roll_ff  [2];
  logic [ptr_pkg::NCNT_W-1:0]    ncnt_ff  [2];
  logic [ptr_pkg::DATA_W-1:0]    wsMem_ff [ptr_pkg::WS_DEPTH];
  logic [ptr_pkg::CMD_W-1:0]     wsTag_ff [ptr_pkg::WS_DEPTH];
  logic [ptr_pkg::WS_DEPTH-1:0]  wsVld_ff;
  logic [ptr_pkg::WS_IDX_W-1:0]  reqIdx;

  // ==========================================================================
  // link reset and ack synchronisers
  always_ff @(posedge linkClk) begin
    linkRstS1_ff <= reset_n;
    linkRstS2_ff <= linkRstS1_ff;
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstS2_ff) begin
      ackS1_ff <= 1'b0;
      ackS2_ff <= 1'b0;
      ackS3_ff <= 1'b0;
    end else begin
      ackS1_ff <= ackTog_ff;
      ackS2_ff <= ackS1_ff;
      ackS3_ff <= ackS2_ff;
    end
  end

  assign ackSeen = ackS2_ff ^ ackS3_ff;

  // ==========================================================================
  // link request channel: one request in flight, reads go before writes
  // a write arriving while the channel is busy is dropped; host cannot
  // issue one while scl is held, so only back-to-back writes, or writes after a stretch timeout, can lose data
  always_ff @(posedge linkClk) begin
    if (!linkRstS2_ff) begin
      lstate_ff    <= ptr_pkg::L_IDLE;
      reqTog_ff    <= 1'b0;
      reqIsRd_ff   <= 1'b0;
      reqCmd_ff    <= '0;
      reqData_ff   <= '0;
      rdPend_ff    <= 1'b0;
      rdPendCmd_ff <= '0;
      timedOut_ff  <= 1'b0;
      holdCnt_ff   <= '0;
      sclHold_ff   <= 1'b0;
      rdValid_ff   <= 1'b0;
      rdTimeout_ff <= 1'b0;
      rdData_ff    <= '0;
    end else begin
      rdValid_ff   <= 1'b0;
      rdTimeout_ff <= 1'b0;
      // stretch timer; releasing scl beats a stuck handshake
      if (sclHold_ff) begin
        holdCnt_ff <= holdCnt_ff + 1'b1;
      end
      if (sclHold_ff && holdCnt_ff == ptr_pkg::STRETCH_CNT_W'(STRETCH_MAX_CYC - 1)) begin
        sclHold_ff   <= 1'b0;
        timedOut_ff  <= 1'b1;
        rdTimeout_ff <= 1'b1;
      end
      unique case (lstate_ff)
        ptr_pkg::L_IDLE: begin
          if (rdPend_ff || rdStrobe) begin
            reqIsRd_ff <= 1'b1;
            reqCmd_ff  <= rdPend_ff ? rdPendCmd_ff : rdCmd;
            reqTog_ff  <= ~reqTog_ff;
            rdPend_ff  <= 1'b0;
            lstate_ff  <= ptr_pkg::L_RD;
            if (rdStrobe) begin
              sclHold_ff  <= 1'b1;
              holdCnt_ff  <= '0;
              timedOut_ff <= 1'b0;
            end
          end else if (wrStrobe) begin
            reqIsRd_ff <= 1'b0;
            reqCmd_ff  <= wrCmd;
            reqData_ff <= wrData;
            reqTog_ff  <= ~reqTog_ff;
            lstate_ff  <= ptr_pkg::L_WR;
          end
        end
        ptr_pkg::L_WR: begin
          // read queued behind the write being stored, scl held meanwhile
          if (rdStrobe) begin
            rdPend_ff    <= 1'b1;
            rdPendCmd_ff <= rdCmd;
            sclHold_ff   <= 1'b1;
            holdCnt_ff   <= '0;
            timedOut_ff  <= 1'b0;
          end
          if (ackSeen) begin
            lstate_ff <= ptr_pkg::L_IDLE;
          end
        end
        ptr_pkg::L_RD: begin
          if (ackSeen) begin
            rdData_ff  <= rsp_ff;
            rdValid_ff <= ~timedOut_ff;
            sclHold_ff <= 1'b0;
            lstate_ff  <= ptr_pkg::L_IDLE;
          end
        end
        default: begin
          lstate_ff <= ptr_pkg::L_IDLE;
        end
      endcase
    end
  end

  assign sclHold   = sclHold_ff;
  assign rdData    = rdData_ff;
  assign rdValid   = rdValid_ff;
  assign rdTimeout = rdTimeout_ff;

  // ==========================================================================
  // system side synchronisers: request toggle and status pins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reqS1_ff  <= 1'b0;
      reqS2_ff  <= 1'b0;
      reqS3_ff  <= 1'b0;
      statS1_ff <= '0;
      statS2_ff <= '0;
    end else begin
      reqS1_ff  <= reqTog_ff;
      reqS2_ff  <= reqS1_ff;
      reqS3_ff  <= reqS2_ff;
      statS1_ff <= {peerPowered, unitOn, acPresent};
      statS2_ff <= statS1_ff;
    end
  end

  assign reqSeen = reqS2_ff ^ reqS3_ff;
  assign acOk    = statS2_ff[0];
  assign onOk    = statS2_ff[1];
  assign peerOk  = statS2_ff[2];
  assign reqIdx  = reqCmd_ff[ptr_pkg::WS_IDX_W-1:0];

  // ==========================================================================
  // filter tick and energy sample period
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tickCnt_ff <= '0;
      tick_ff    <= 1'b0;
      sampCnt_ff <= '0;
    end else begin
      tick_ff <= (tickCnt_ff == ptr_pkg::FILT_CNT_W'(FILT_TICK_CYC - 1));
      if (tickCnt_ff == ptr_pkg::FILT_CNT_W'(FILT_TICK_CYC - 1)) begin
        tickCnt_ff <= '0;
      end else begin
        tickCnt_ff <= tickCnt_ff + 1'b1;
      end
      if (tick_ff) begin
        sampCnt_ff <= sampCnt_ff + 1'b1;
      end
    end
  end

  assign sampStrobe = tick_ff && (sampCnt_ff == ptr_pkg::SAMPLE_LAST);

  // ==========================================================================
  // filter inputs: forced readings for lost ac and standby
  always_comb begin
    filtIn[0]   = rawPinW;
    filtZero[0] = ~acOk;
    filtIn[1]   = rawIoutA8;
    filtZero[1] = ~onOk;
    engIn[0]    = acOk ? rawPinW : '0;
    engIn[1]    = (acOk && onOk) ? rawPoutW : '0;
  end

  // ==========================================================================
  // first-order low-pass per channel, held at zero while its filtZero is set
  for (genvar k = 0; k < 2; k++) begin : g_filt
    logic signed [ptr_pkg::FILT_W:0] diff;
    assign diff = $signed({1'b0, filtIn[k], ptr_pkg::FRAC_W'(0)})
                - $signed({1'b0, filt_ff[k]});
    always_ff @(posedge sys_clk) begin
      if (!reset_n || filtZero[k]) begin
        filt_ff[k] <= '0;
      end else if (tick_ff) begin
        filt_ff[k] <= ptr_pkg::FILT_W'($signed({1'b0, filt_ff[k]})
                                      + (diff >>> ptr_pkg::FILT_SHIFT));
      end
    end
  end

  // ==========================================================================
  // all supplies down: remember so that returning ac clears the counters
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lostAll_ff <= 1'b0;
    end else if (!acOk && !peerOk) begin
      lostAll_ff <= 1'b1;
    end else if (acOk) begin
      lostAll_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // energy accumulators: ein from input power, eout from output power
  for (genvar e = 0; e < 2; e++) begin : g_energy
    logic [ptr_pkg::PSUM_W-1:0] total;
    logic [ptr_pkg::DATA_W-1:0] avg;
    logic [ptr_pkg::PACC_W-1:0] psample;
    logic [ptr_pkg::PACC_W:0]   accSum;
    assign total   = psum_ff[e] + ptr_pkg::PSUM_W'(engIn[e]);
    assign avg     = ptr_pkg::DATA_W'(total >> ptr_pkg::SAMPLE_SHIFT);
    assign psample = (avg > ptr_pkg::DATA_W'(ptr_pkg::PACC_MAX)) ? ptr_pkg::PACC_MAX
                                                                 : avg[ptr_pkg::PACC_W-1:0];
    assign accSum  = {1'b0, pacc_ff[e]} + {1'b0, psample};
    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        psum_ff[e] <= '0;
        pacc_ff[e] <= '0;
        roll_ff[e] <= '0;
        ncnt_ff[e] <= '0;
      end else if (lostAll_ff && acOk) begin
        psum_ff[e] <= '0;
        pacc_ff[e] <= '0;
        roll_ff[e] <= '0;
        ncnt_ff[e] <= '0;
      end else if (sampStrobe) begin
        psum_ff[e] <= '0;
        if (acOk || peerOk) begin
          pacc_ff[e] <= accSum[ptr_pkg::PACC_W-1:0];
          roll_ff[e] <= roll_ff[e] + ptr_pkg::ROLL_W'(accSum[ptr_pkg::PACC_W]);
          ncnt_ff[e] <= ncnt_ff[e] + 1'b1;
        end
      end else if (tick_ff) begin
        psum_ff[e] <= total;
      end
    end
  end

  // ==========================================================================
  // request service: store writes, build read answers from one snapshot
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ackTog_ff <= 1'b0;
      rsp_ff    <= '0;
      wsVld_ff  <= '0;
    end else if (reqSeen) begin
      ackTog_ff <= ~ackTog_ff;
      if (!reqIsRd_ff) begin
        wsVld_ff[reqIdx] <= 1'b1;
      end else begin
        unique case (reqCmd_ff)
          ptr_pkg::CMD_READ_EIN,
          ptr_pkg::CMD_READ_EOUT: begin
            rsp_ff <= {ncnt_ff[reqCmd_ff[0]], roll_ff[reqCmd_ff[0]],
                       1'b0, pacc_ff[reqCmd_ff[0]]};
          end
          ptr_pkg::CMD_READ_PIN: begin
            rsp_ff <= ptr_pkg::RSP_W'(ptr_pkg::lin_enc(ptr_pkg::EXP_WATT,
                      filt_ff[0][ptr_pkg::FILT_W-1:ptr_pkg::FRAC_W]));
          end
          ptr_pkg::CMD_READ_IOUT: begin
            rsp_ff <= ptr_pkg::RSP_W'(ptr_pkg::lin_enc(ptr_pkg::EXP_AMP,
                      filt_ff[1][ptr_pkg::FILT_W-1:ptr_pkg::FRAC_W]));
          end
          ptr_pkg::CMD_READ_TEMP1: begin
            rsp_ff <= ptr_pkg::RSP_W'({ptr_pkg::EXP_TEMP, rawTempInlet});
          end
          ptr_pkg::CMD_READ_TEMP2: begin
            rsp_ff <= ptr_pkg::RSP_W'({ptr_pkg::EXP_TEMP, rawTempHot});
          end
          default: begin
            // stored word of a written command, zero when never written
            rsp_ff <= (wsVld_ff[reqIdx] && wsTag_ff[reqIdx] == reqCmd_ff)
                    ? ptr_pkg::RSP_W'(wsMem_ff[reqIdx]) : '0;
          end
        endcase
      end
    end
  end

  // write store contents; no reset needed, guarded by the valid bits
  always_ff @(posedge sys_clk) begin
    if (reqSeen && !reqIsRd_ff) begin
      wsMem_ff[reqIdx] <= reqData_ff;
      wsTag_ff[reqIdx] <= reqCmd_ff;
    end
  end

endmodule : ptr_pmbus_telemetry

// file: bench/ptr_pmbus_telemetry_assertions.sv
// link handshake checker of the pmbus telemetry responder
module ptr_pmbus_telemetry_assertions #(
  parameter int FILT_TICK_CYC   = 20,  // filter update period
  parameter int STRETCH_MAX_CYC = 200  // stretch limit, link cycles
) (
  input wire logic reset_n,   // synchronous reset
  input wire logic linkClk,   // link clock
  input wire logic wrStrobe,  // write pulse
  input wire logic rdStrobe,  // read pulse
  input wire logic sclHold,   // stretch request
  input wire logic rdValid,   // answer pulse
  input wire logic rdTimeout  // stretch limit pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned holdCnt_ff;

  // ==========================================================================
  // stretch length; a counter because the limit is far too long to unroll
  always_ff @(posedge linkClk) begin
    if (!reset_n || !sclHold) holdCnt_ff <= 0;
    else holdCnt_ff <= holdCnt_ff + 1;
  end

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // assertions
  a_read_stretches: assert property (rdStrobe && !sclHold && !rdValid |=> sclHold)
    else $error("read did not stretch the clock");
  a_read_answered: assert property (rdStrobe && !sclHold |-> ##[2:1000] (rdValid || rdTimeout))
    else $error("read got neither answer nor timeout");
  a_hold_release: assert property ($fell(sclHold) |-> rdValid || rdTimeout)
    else $error("stretch released without an answer");
  a_valid_after_hold: assert property (rdValid |-> !sclHold && $past(sclHold))
    else $error("answer not at the end of a stretch");
  a_valid_pulse: assert property (rdValid |=> !rdValid)
    else $error("answer pulse longer than one cycle");
  a_timeout_pulse: assert property (rdTimeout |=> !rdTimeout && !rdValid)
    else $error("timeout pulse wrong");
  a_stretch_bound: assert property (holdCnt_ff <= STRETCH_MAX_CYC + 1)
    else $error("stretch longer than the limit");
  a_timeout_at_limit: assert property (rdTimeout |-> holdCnt_ff + 1 >= STRETCH_MAX_CYC)
    else $error("timeout before the limit");
  a_write_no_hold: assert property (wrStrobe && !sclHold && !rdStrobe |=> !sclHold)
    else $error("lone write stretched the clock");
endmodule : ptr_pmbus_telemetry_assertions

bind ptr_pmbus_telemetry ptr_pmbus_telemetry_assertions #(
  .FILT_TICK_CYC(FILT_TICK_CYC), .STRETCH_MAX_CYC(STRETCH_MAX_CYC)
) i_ptr_pmbus_telemetry_assertions (.reset_n(reset_n), .linkClk(linkClk),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .sclHold(sclHold), .rdValid(rdValid),
  .rdTimeout(rdTimeout));

// file: bench/ptr_host_model.sv
// host model issuing word writes and reads on the link clock
module ptr_host_model (
  input  wire logic                      linkClk,   // link clock
  input  wire logic                      rdValid,   // answer pulse
  input  wire logic                      rdTimeout, // stretch limit pulse
  output logic                           wrStrobe,  // write pulse
  output logic [ptr_pkg::CMD_W-1:0]      wrCmd,     // write command
  output logic [ptr_pkg::DATA_W-1:0]     wrData,    // write word
  output logic                           rdStrobe,  // read pulse
  output logic [ptr_pkg::CMD_W-1:0]      rdCmd      // read command
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // idle lines at time zero
  initial begin
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    wrCmd    = 8'h00;
    wrData   = 16'h0000;
    rdCmd    = 8'h00;
  end

  // optional write, the read right behind it, then wait for the answer
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge linkClk);
    if (wr) begin
      wrStrobe <= 1'b1;
      wrCmd    <= c;
      wrData   <= d;
      @(posedge linkClk);
      wrStrobe <= 1'b0;
      wrCmd    <= ~c;  // released lines carry garbage, not the old word
      wrData   <= ~d;
    end
    rdStrobe <= 1'b1;
    rdCmd    <= c;
    @(posedge linkClk);
    rdStrobe <= 1'b0;
    rdCmd    <= ~c;
    while (!(rdValid === 1'b1 || rdTimeout === 1'b1) && n < 400) begin
      @(posedge linkClk);
      n++;
    end
  endtask : xfer
endmodule : ptr_host_model

// file: bench/ptr_pmbus_telemetry_bench.sv
// self-checking bench of the pmbus telemetry responder
module ptr_pmbus_telemetry_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {string what; int kind; logic [47:0] exp; logic [47:0] mask; int tol;} ptr_note_t;
  localparam logic [47:0] FULL = 48'hffffffffffff;
  logic sys_clk, reset_n, acPresent, unitOn, peerPowered, linkClk;
  logic wrStrobe, rdStrobe, sclHold, rdValid, rdTimeout;
  logic [15:0] rawPinW, rawIoutA8, rawPoutW, wrData, wd;
  logic [10:0] rawTempInlet, rawTempHot;
  logic [7:0]  wrCmd, rdCmd;
  logic [47:0] rdData, lastE, pr;
  int          errors, total_checks, seed;
  ptr_note_t   notes[$];
  ptr_note_t   nt;

  ptr_pmbus_telemetry #(.FILT_TICK_CYC(20), .STRETCH_MAX_CYC(200)) i_ptr_pmbus_telemetry (
    .sys_clk(sys_clk), .reset_n(reset_n), .acPresent(acPresent), .unitOn(unitOn),
    .peerPowered(peerPowered), .rawPinW(rawPinW), .rawIoutA8(rawIoutA8), .rawPoutW(rawPoutW),
    .rawTempInlet(rawTempInlet), .rawTempHot(rawTempHot), .linkClk(linkClk),
    .wrStrobe(wrStrobe), .wrCmd(wrCmd), .wrData(wrData), .rdStrobe(rdStrobe), .rdCmd(rdCmd),
    .sclHold(sclHold), .rdData(rdData), .rdValid(rdValid), .rdTimeout(rdTimeout));
  ptr_host_model i_ptr_host_model (.linkClk(linkClk), .rdValid(rdValid), .rdTimeout(rdTimeout),
    .wrStrobe(wrStrobe), .wrCmd(wrCmd), .wrData(wrData), .rdStrobe(rdStrobe), .rdCmd(rdCmd));

  // ==========================================================================
  // clocks: link clock offset so the two edges never line up
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    linkClk = 1'b0;
    #2;
    forever #6 linkClk = ~linkClk;
  end

  // ==========================================================================
  // compare, note and finish helpers
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp,
                       input int tol);
    logic [47:0] d;
    d = (seen > exp) ? seen - exp : exp - seen;
    total_checks++;
    if (!(seen === exp || (tol > 0 && !$isunknown(seen) && d <= 48'(tol)))) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic ask(input string s, input int k, input logic [7:0] c, input logic [47:0] e,
                     input logic [47:0] m, input int t);
    notes.push_back('{s, k, e, m, t});
    i_ptr_host_model.xfer(1'b0, c, 16'h0000);
  endtask : ask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // watcher: each answer against the oldest note; kind 1 energy checks relate its own fields, kind 2 compare with the previous answer
  always @(posedge linkClk) begin
    if (reset_n === 1'b1 && rdTimeout !== 1'b0)
      check("stretch timeout", 48'(rdTimeout), 48'h0, 0);
    if (rdValid === 1'b1 && notes.size() == 0) check("unasked answer", 48'h1, 48'h0, 0);
    else if (rdValid === 1'b1) begin
      nt = notes.pop_front();
      pr = rdData[47:24] * nt.exp[15:0];
      case (nt.kind)
        0: check(nt.what, rdData & nt.mask, nt.exp, nt.tol);
        1: begin
          check(nt.what, rdData, {rdData[47:24], pr[22:15], 1'b0, pr[14:0]}, 0);
          check("sample count", 48'($isunknown(rdData) || rdData[47:24] == 24'h0 ||
                rdData[47:24] > nt.exp[47:24]), 0, 0);
        end
        2: begin
          check(nt.what, 48'(rdData[23:0]), 48'(lastE[23:0]), 0);
          check("count advance", 48'(rdData[47:24] > lastE[47:24]), 48'h1, 0);
        end
        default: ;
      endcase
      lastE = rdData;
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed = 32196;
    reset_n = 1'b0;
    acPresent = 1'b1;
    unitOn = 1'b1;
    peerPowered = 1'b0;
    rawPinW = 16'h1000;
    rawIoutA8 = 16'h0050;
    rawPoutW = 16'h0200;
    rawTempInlet = 11'($random(seed));
    rawTempHot = 11'($random(seed));
    // five cycles so the slower link side also sees four edges
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      wd = 16'($random(seed));
      notes.push_back('{"write readback", 0, {32'h0, wd}, FULL, 0});
      i_ptr_host_model.xfer(1'b1, 8'h20 + 8'(i), wd);
    end
    repeat (6000) @(posedge sys_clk);
    ask("input power", 0, ptr_pkg::CMD_READ_PIN, {32'h0, 5'h00, 11'h3ff}, FULL, 0);
    ask("output current", 0, ptr_pkg::CMD_READ_IOUT, {32'h0, 5'h1d, 11'h050}, FULL, 1);
    ask("input energy", 1, ptr_pkg::CMD_READ_EIN, {24'hffffff, 24'h1000}, FULL, 0);
    ask("output energy", 1, ptr_pkg::CMD_READ_EOUT, {24'hffffff, 24'h0200}, FULL, 0);
    // standby: no output current, output energy stands still
    @(posedge sys_clk);
    unitOn <= 1'b0;
    repeat (200) @(posedge sys_clk);
    ask("standby current", 0, ptr_pkg::CMD_READ_IOUT, 48'h0, 48'h7ff, 0);
    ask("standby input energy", 1, ptr_pkg::CMD_READ_EIN, {24'hffffff, 24'h1000}, FULL, 0);
    ask("eout mark", 3, ptr_pkg::CMD_READ_EOUT, 48'h0, 48'h0, 0);
    repeat (400) @(posedge sys_clk);
    ask("standby output energy", 2, ptr_pkg::CMD_READ_EOUT, 48'h0, 48'h0, 0);
    // own ac gone, a paralleled supply keeps the bus alive
    @(posedge sys_clk);
    unitOn <= 1'b1;
    acPresent <= 1'b0;
    peerPowered <= 1'b1;
    // current filter restarts from zero after standby: let it settle first
    repeat (4000) @(posedge sys_clk);
    ask("input power off", 0, ptr_pkg::CMD_READ_PIN, 48'h0, 48'h7ff, 0);
    ask("peer current", 0, ptr_pkg::CMD_READ_IOUT, {32'h0, 5'h1d, 11'h050}, FULL, 1);
    ask("inlet", 0, ptr_pkg::CMD_READ_TEMP1, {32'h0, 5'h00, rawTempInlet}, FULL, 0);
    ask("hot spot", 0, ptr_pkg::CMD_READ_TEMP2, {32'h0, 5'h00, rawTempHot}, FULL, 0);
    ask("ein mark", 3, ptr_pkg::CMD_READ_EIN, 48'h0, 48'h0, 0);
    repeat (400) @(posedge sys_clk);
    ask("peer input energy", 2, ptr_pkg::CMD_READ_EIN, 48'h0, 48'h0, 0);
    // every supply dark, then ac returns and the energy counters start over
    @(posedge sys_clk);
    peerPowered <= 1'b0;
    repeat (200) @(posedge sys_clk);
    // ac returns on a sample edge (every 160 cycles, phase 5 after reset), so no
    // new sample lands before the read and every field must read zero
    while (($time - 5) / 10 % 160 != 5) @(posedge sys_clk);
    acPresent <= 1'b1;
    repeat (8) @(posedge sys_clk);
    ask("energy cleared", 0, ptr_pkg::CMD_READ_EIN, 48'h0, FULL, 0);
    repeat (50) @(posedge linkClk);
    check("pending answers", 48'(notes.size()), 48'h0, 0);
    print_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
endmodule : ptr_pmbus_telemetry_bench
